/* File: design/bfxbr_pkg.sv */
// Package for the bitfield, extend and branch execution block.
// Assumes a decoder that presents one decoded operation per cycle.
package bfxbr_pkg;

    // Operation codes presented by the decoder
    typedef enum logic [3:0] {
        BFXBR_OP_NONE = 4'h0,
        BFXBR_OP_SFX = 4'h1,
        BFXBR_OP_UFX = 4'h2,
        BFXBR_OP_FCLR = 4'h3,
        BFXBR_OP_FINS = 4'h4,
        BFXBR_OP_SBYTE = 4'h5,
        BFXBR_OP_UBYTE = 4'h6,
        BFXBR_OP_SHALF = 4'h7,
        BFXBR_OP_UHALF = 4'h8,
        BFXBR_OP_BIMM = 4'h9,
        BFXBR_OP_CALL_IMM = 4'hA,
        BFXBR_OP_JUMP_IND = 4'hB,
        BFXBR_OP_CALL_IND = 4'hC,
        BFXBR_OP_ZTEST = 4'hD,
        BFXBR_OP_NZTEST = 4'hE,
        BFXBR_OP_ITPFX = 4'hF
    } bfxbr_op_t;

    localparam logic [3:0] BFXBR_LINK_REG = 4'hE;
    localparam logic [3:0] BFXBR_COND_ALWAYS = 4'hE;
    localparam int BFXBR_IT_MAX = 4;
    localparam logic [31:0] BFXBR_NEAR_MIN = 32'hFFF0_0000;
    localparam logic [31:0] BFXBR_NEAR_MAX = 32'h000F_FFFE;
    localparam logic [31:0] BFXBR_FAR_MIN = 32'hFF00_0000;
    localparam logic [31:0] BFXBR_FAR_MAX = 32'h00FF_FFFE;
    localparam logic [4:0] BFXBR_ROT_BYTES = 5'h08;
    localparam logic [7:0] BFXBR_IT_RESET = 8'h00;

endpackage

/* File: design/bfxbr_cond.sv */
// Condition-code evaluator for the branch and control group.
// Assumes flags are stable during the cycle the condition is used.
`timescale 1ns/100ps
module bfxbr_cond
    import bfxbr_pkg::*;
(
    // Condition and flags
    input wire logic [3:0] cond_i,
    input wire logic [3:0] nzcv_i,
    // Result
    output logic pass_o
);
    logic n;
    logic z;
    logic c;
    logic v;
    logic base;
    always_comb begin
        {n, z, c, v} = nzcv_i;
        unique case (cond_i[3:1])
            3'h0: base = z;
            3'h1: base = c;
            3'h2: base = n;
            3'h3: base = v;
            3'h4: base = c & ~z;
            3'h5: base = (n == v);
            3'h6: base = ~z & (n == v);
            3'h7: base = 1'b1;
        endcase
        // Code 0xF behaves as always as well
        if (cond_i[3:1] == 3'h7) begin
            pass_o = 1'b1;
        end else begin
            pass_o = base ^ cond_i[0];
        end
    end
endmodule

/* File: design/bfxbr_exec.sv */
// Execution unit for field extract/clear/insert, byte and half extend,
// branches, zero-test branches and the if-then prefix.
// Assumes the decoder keeps operand and encoding rules; one op per cycle.
//
// Notes on behaviour
// (RQ1) Signed extract sign-extends field to 32 bits
// (RQ2) Unsigned extract zero-extends field to 32 bits
// (RQ3) Software keeps lsb 0-31, width 1..32-lsb
// (RQ4) Field and extend ops keep flags
// (RQ5) No stack pointer or program counter operands
// (RQ6) Extends rotate operand right 0/8/16/24 first
// (RQ7) Byte extends take rotated bits 7:0
// (RQ8) Half extends take rotated bits 15:0
// (RQ9) Calls write next address into R14
// (RQ10) Indirect target clears operand bit 0
// (RQ11) Indirect branch faults when operand bit 0 zero
// (RQ12) Offsets: 16 MB generally, 1 MB conditional outside
// (RQ13) Only conditional immediate branch outside blocks
// (RQ14) Branch in block must be last slot
// (RQ15) Indirect call never uses program counter
// (RQ16) Branches and zero-tests keep flags
// (RQ17) Zero-tests compare operand with zero, no flags
// (RQ18) Zero-test operand R0-R7, target 4..130 forward
// (RQ19) Zero-tests never inside if-then block
// (RQ20) First slot uses condition, others same or inverse
// (RQ21) Always condition never uses inverse switches
// (RQ22) Field clear zeroes width bits at lsb
// (RQ23) Field insert copies low source bits in
// (RQ24) If-then covers at most four instructions
// (RQ25) Conditions use current flags at execution
`timescale 1ns/100ps
module bfxbr_exec
    import bfxbr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Decoded operation
    input wire logic op_valid_i,
    input wire bfxbr_op_t op_i,
    input wire logic [3:0] cond_i,
    input wire logic [3:0] dest_reg_i,
    input wire logic [4:0] lsb_i,
    input wire logic [5:0] width_i,
    input wire logic [1:0] rot_i,
    input wire logic [3:0] it_mask_i,
    input wire logic [31:0] imm_offset_i,
    // Operands and state
    input wire logic [31:0] first_source_reg_i,
    input wire logic [31:0] operand_reg_i,
    input wire logic [31:0] dest_old_i,
    input wire logic [31:0] program_counter_i,
    input wire logic [31:0] next_addr_i,
    input wire logic [3:0] nzcv_i,
    // Register write-back
    output logic wr_en_o,
    output logic [3:0] wr_reg_o,
    output logic [31:0] wr_data_o,
    // Program counter control
    output logic branch_o,
    output logic [31:0] branch_target_o,
    output logic invalid_state_fault_o,
    // If-then state seen by the next instructions
    output logic in_it_block_o,
    output logic slot_pass_o
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] field_mask(input logic [4:0] lsb,
                                               input logic [5:0] width);
        logic [63:0] ones;
        ones = (64'h1 << width) - 64'h1;
        field_mask = ones[31:0] << lsb;
    endfunction

    function automatic logic [31:0] sext(input logic [31:0] v,
                                         input logic [5:0] width);
        logic [5:0] sh;
        sh = 6'h20 - width;
        sext = 32'($signed(v << sh) >>> sh);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // If-then state: condition and remaining switch mask
    logic [3:0] it_cond_q;
    logic [3:0] it_cond_d;
    logic [3:0] it_mask_q;
    logic [3:0] it_mask_d;
    logic it_flip_q;
    logic it_flip_d;
    logic slot_cond_pass;
    logic op_cond_pass;
    logic [3:0] slot_cond;
    logic [3:0] eff_cond;

    assign in_it_block_o = (it_mask_q != 4'h0);
    // Slot condition: low bit of the base code flipped by the switch
    assign slot_cond = {it_cond_q[3:1], it_cond_q[0] ^ it_flip_q}; // RQ20
    assign eff_cond = in_it_block_o ? slot_cond : cond_i;

    bfxbr_cond u_slot_cond (
        .cond_i(slot_cond),
        .nzcv_i(nzcv_i), // RQ25
        .pass_o(slot_cond_pass)
    );
    bfxbr_cond u_op_cond (
        .cond_i(eff_cond),
        .nzcv_i(nzcv_i), // RQ25
        .pass_o(op_cond_pass)
    );
    assign slot_pass_o = in_it_block_o ? slot_cond_pass : 1'b1;

    // Mask: top bit is the next slot's switch, a lone 1 marks the end
    always_comb begin
        it_cond_d = it_cond_q;
        it_mask_d = it_mask_q;
        it_flip_d = it_flip_q;
        if (op_valid_i) begin
            if (op_i == BFXBR_OP_ITPFX && !in_it_block_o) begin
                it_cond_d = cond_i; // RQ20
                // First slot takes the base condition as it stands
                it_flip_d = 1'b0;
                // Four-bit mask limits the block to four slots
                it_mask_d = it_mask_i; // RQ24
            end else if (in_it_block_o) begin
                // Bit shifted out is the switch of the slot that follows
                it_flip_d = it_mask_q[3];
                it_mask_d = (it_mask_q[2:0] == 3'h0) ? 4'h0 : {it_mask_q[2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            it_cond_q <= BFXBR_IT_RESET[3:0];
            it_mask_q <= BFXBR_IT_RESET[7:4];
            it_flip_q <= 1'b0;
        end else begin
            it_cond_q <= it_cond_d;
            it_mask_q <= it_mask_d;
            it_flip_q <= it_flip_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath and branch decision
    logic [31:0] rotated;
    logic [31:0] fmask;
    logic [31:0] extracted;
    logic [31:0] wr_data_d;
    logic [31:0] target_d;
    logic [31:0] offset_lim;
    logic wr_en_d;
    logic [3:0] wr_reg_d;
    logic branch_d;
    logic fault_d;
    logic exec;
    logic [4:0] rot_amt;

    assign rot_amt = 5'(rot_i * BFXBR_ROT_BYTES);
    assign rotated = (operand_reg_i >> rot_amt) | (operand_reg_i << (6'h20 - rot_amt)); // RQ6
    assign fmask = field_mask(lsb_i, width_i);
    assign extracted = (first_source_reg_i >> lsb_i) & field_mask(5'h00, width_i);
    // Condition failures suppress all effects
    assign exec = op_valid_i & op_cond_pass;

    always_comb begin
        wr_en_d = 1'b0;
        wr_reg_d = dest_reg_i;
        wr_data_d = 32'h0000_0000;
        branch_d = 1'b0;
        target_d = 32'h0000_0000;
        fault_d = 1'b0;
        // Immediate branch and call offsets beyond reach are clipped to the documented range
        offset_lim = imm_offset_i;
        if (exec) begin
            unique case (op_i)
                BFXBR_OP_SFX: begin
                    wr_en_d = 1'b1;
                    wr_data_d = sext(extracted, width_i); // RQ1
                end
                BFXBR_OP_UFX: begin
                    wr_en_d = 1'b1;
                    wr_data_d = extracted; // RQ2
                end
                BFXBR_OP_FCLR: begin
                    wr_en_d = 1'b1;
                    wr_data_d = dest_old_i & ~fmask; // RQ22
                end
                BFXBR_OP_FINS: begin
                    wr_en_d = 1'b1;
                    wr_data_d = (dest_old_i & ~fmask)
                        | ((first_source_reg_i << lsb_i) & fmask); // RQ23
                end
                BFXBR_OP_SBYTE: begin
                    wr_en_d = 1'b1;
                    wr_data_d = {{24{rotated[7]}}, rotated[7:0]}; // RQ7
                end
                BFXBR_OP_UBYTE: begin
                    wr_en_d = 1'b1;
                    wr_data_d = {24'h00_0000, rotated[7:0]}; // RQ7
                end
                BFXBR_OP_SHALF: begin
                    wr_en_d = 1'b1;
                    wr_data_d = {{16{rotated[15]}}, rotated[15:0]}; // RQ8
                end
                BFXBR_OP_UHALF: begin
                    wr_en_d = 1'b1;
                    wr_data_d = {16'h0000, rotated[15:0]}; // RQ8
                end
                BFXBR_OP_BIMM, BFXBR_OP_CALL_IMM: begin
                    // Near reach only for a conditional branch outside a block
                    if (op_i == BFXBR_OP_BIMM && !in_it_block_o
                        && cond_i != BFXBR_COND_ALWAYS) begin
                        if ($signed(imm_offset_i) < $signed(BFXBR_NEAR_MIN)) begin
                            offset_lim = BFXBR_NEAR_MIN; // RQ12
                        end else if ($signed(imm_offset_i) > $signed(BFXBR_NEAR_MAX)) begin
                            offset_lim = BFXBR_NEAR_MAX; // RQ12
                        end
                    end else if ($signed(imm_offset_i) < $signed(BFXBR_FAR_MIN)) begin
                        offset_lim = BFXBR_FAR_MIN; // RQ12
                    end else if ($signed(imm_offset_i) > $signed(BFXBR_FAR_MAX)) begin
                        offset_lim = BFXBR_FAR_MAX; // RQ12
                    end
                    branch_d = 1'b1;
                    target_d = program_counter_i + offset_lim;
                    if (op_i == BFXBR_OP_CALL_IMM) begin
                        wr_en_d = 1'b1;
                        wr_reg_d = BFXBR_LINK_REG;
                        wr_data_d = next_addr_i; // RQ9
                    end
                end
                BFXBR_OP_JUMP_IND, BFXBR_OP_CALL_IND: begin
                    if (!operand_reg_i[0]) begin
                        // Faulting branch neither jumps nor links
                        fault_d = 1'b1; // RQ11
                    end else begin
                        branch_d = 1'b1;
                        target_d = {operand_reg_i[31:1], 1'b0}; // RQ10
                        if (op_i == BFXBR_OP_CALL_IND) begin
                            wr_en_d = 1'b1;
                            wr_reg_d = BFXBR_LINK_REG;
                            wr_data_d = next_addr_i; // RQ9
                        end
                    end
                end
                BFXBR_OP_ZTEST, BFXBR_OP_NZTEST: begin
                    // Comparison done here, flags never touched
                    branch_d = (operand_reg_i == 32'h0000_0000)
                        == (op_i == BFXBR_OP_ZTEST); // RQ17
                    target_d = program_counter_i + imm_offset_i;
                end
                BFXBR_OP_ITPFX, BFXBR_OP_NONE: begin
                    wr_en_d = 1'b0;
                end
            endcase
        end
    end

    // No flag output exists: field, extend and branch ops leave flags alone
    always_ff @(posedge sys_clk_i) begin // RQ4 RQ16
        if (!reset_n_i) begin
            wr_en_o <= 1'b0;
            wr_reg_o <= 4'h0;
            wr_data_o <= 32'h0000_0000;
            branch_o <= 1'b0;
            branch_target_o <= 32'h0000_0000;
            invalid_state_fault_o <= 1'b0;
        end else begin
            wr_en_o <= wr_en_d;
            wr_reg_o <= wr_reg_d;
            wr_data_o <= wr_data_d;
            branch_o <= branch_d;
            branch_target_o <= target_d;
            invalid_state_fault_o <= fault_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_ind_fault: assert property ( // RQ11
        op_valid_i && op_cond_pass && (op_i inside {BFXBR_OP_JUMP_IND, BFXBR_OP_CALL_IND})
        && !operand_reg_i[0] |=> invalid_state_fault_o && !branch_o)
        else $error("indirect branch with bit 0 clear did not fault");
    a_ind_target: assert property ( // RQ10
        exec && op_i == BFXBR_OP_JUMP_IND && operand_reg_i[0]
        |=> branch_o && branch_target_o == {$past(operand_reg_i[31:1]), 1'b0})
        else $error("indirect target wrong");
    a_call_link: assert property ( // RQ9
        exec && op_i == BFXBR_OP_CALL_IMM
        |=> wr_en_o && wr_reg_o == 4'hE && wr_data_o == $past(next_addr_i))
        else $error("call did not link");
    a_ubyte_ext: assert property ( // RQ7
        exec && op_i == BFXBR_OP_UBYTE |=> wr_data_o[31:8] == 24'h00_0000)
        else $error("byte zero extend wrong");
    a_shalf_ext: assert property ( // RQ8
        exec && op_i == BFXBR_OP_SHALF |=> wr_data_o[31:16] == {16{wr_data_o[15]}})
        else $error("half sign extend wrong");
    a_ztest_take: assert property ( // RQ17
        exec && op_i == BFXBR_OP_ZTEST && operand_reg_i == 32'h0000_0000 |=> branch_o)
        else $error("zero-test did not branch");
    a_ufx_field: assert property ( // RQ2
        exec && op_i == BFXBR_OP_UFX && width_i == 6'h04
        |=> wr_data_o == ($past(first_source_reg_i >> lsb_i) & 32'h0000_000F))
        else $error("unsigned extract wrong");
    a_fclr_bits: assert property ( // RQ22
        exec && op_i == BFXBR_OP_FCLR |=> (wr_data_o & $past(fmask)) == 32'h0000_0000)
        else $error("field clear left bits set");
    a_it_limit: assert property ( // RQ24
        (in_it_block_o && op_valid_i) [*4] |=> !in_it_block_o)
        else $error("if-then block longer than four");
    a_near_reach: assert property ( // RQ12
        exec && op_i == BFXBR_OP_BIMM && !in_it_block_o && cond_i != BFXBR_COND_ALWAYS
        && $signed(imm_offset_i) > $signed(BFXBR_NEAR_MAX)
        |=> branch_target_o == $past(program_counter_i) + BFXBR_NEAR_MAX)
        else $error("near branch went beyond its reach");
    a_fail_quiet: assert property ( // RQ20
        op_valid_i && !op_cond_pass |=> !wr_en_o && !branch_o)
        else $error("failed condition had effect");

    c_call_ind: cover property (exec && op_i == BFXBR_OP_CALL_IND && operand_reg_i[0]);
    c_it_four: cover property (op_valid_i && op_i == BFXBR_OP_ITPFX && it_mask_i[0]);
    c_fault: cover property (invalid_state_fault_o);
    c_sfx: cover property (exec && op_i == BFXBR_OP_SFX);

endmodule

/* File: verif/bfxbr_rf_model.sv */
// Far-side model: register file and program counter fed by the
// execution block's write-back and branch outputs.
// Assumes the shared clock and the synchronous active-low reset.
`timescale 1ns/100ps
module bfxbr_rf_model #(
    parameter logic [31:0] START_PC = 32'h0000_1000
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Traffic from the block
    input wire logic op_valid_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_reg_i,
    input wire logic [31:0] wr_data_i,
    input wire logic branch_i,
    input wire logic [31:0] branch_target_i,
    // State seen by the block and the bench
    input wire logic [3:0] rd_reg_i,
    output logic [31:0] rd_data_o,
    output logic [31:0] pc_o,
    output logic [31:0] next_addr_o
);
    logic [31:0] regs_q [16];
    logic [31:0] pc_q;

    assign pc_o = pc_q;
    // Only wide instructions are modelled, so the return address is pc plus 4
    assign next_addr_o = pc_q + 32'h0000_0004;
    assign rd_data_o = regs_q[rd_reg_i];

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            pc_q <= START_PC;
            for (int i = 0; i < 16; i++) begin
                regs_q[i] <= 32'h0000_0000;
            end
        end else begin
            if (branch_i) begin
                pc_q <= branch_target_i;
            end else if (op_valid_i) begin
                pc_q <= pc_q + 32'h0000_0004;
            end
            if (wr_en_i) begin
                regs_q[wr_reg_i] <= wr_data_i;
            end
        end
    end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the bitfield, extend and branch execution block.
// Assumes the far-side model supplies program counter and return address.
`timescale 1ns/100ps
module testbench
    import bfxbr_pkg::*;
;
    logic sys_clk_i, reset_n_i, op_valid_i;
    bfxbr_op_t op_i;
    logic [3:0] cond_i, dest_reg_i, it_mask_i, nzcv_i, wr_reg_o, exp_dst, flags_v, mask_v;
    logic [4:0] lsb_i;
    logic [5:0] width_i;
    logic [1:0] rot_i;
    logic [31:0] imm_offset_i, first_source_reg_i, operand_reg_i, dest_old_i, old_v;
    logic [31:0] pc, nxt, r14, wr_data_o, branch_target_o, pc_cap;
    logic wr_en_o, branch_o, invalid_state_fault_o, in_it_block_o, slot_pass_o;
    int fail_count, compares;

    bfxbr_exec DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .op_valid_i(op_valid_i),
        .op_i(op_i), .cond_i(cond_i), .dest_reg_i(dest_reg_i), .lsb_i(lsb_i),
        .width_i(width_i), .rot_i(rot_i), .it_mask_i(it_mask_i), .imm_offset_i(imm_offset_i),
        .first_source_reg_i(first_source_reg_i), .operand_reg_i(operand_reg_i),
        .dest_old_i(dest_old_i), .program_counter_i(pc), .next_addr_i(nxt), .nzcv_i(nzcv_i),
        .wr_en_o(wr_en_o), .wr_reg_o(wr_reg_o), .wr_data_o(wr_data_o), .branch_o(branch_o),
        .branch_target_o(branch_target_o), .invalid_state_fault_o(invalid_state_fault_o),
        .in_it_block_o(in_it_block_o), .slot_pass_o(slot_pass_o));
    bfxbr_rf_model MDL (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .op_valid_i(op_valid_i),
        .wr_en_i(wr_en_o), .wr_reg_i(wr_reg_o), .wr_data_i(wr_data_o), .branch_i(branch_o),
        .branch_target_i(branch_target_o), .rd_reg_i(BFXBR_LINK_REG), .rd_data_o(r14),
        .pc_o(pc), .next_addr_o(nxt));

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One op held for one edge; outputs are looked at just after the answer edge
    task automatic issue(input bfxbr_op_t op, input logic [3:0] cond, input logic [31:0] v,
                         input logic [4:0] lsb, input logic [5:0] w, input logic [1:0] rot,
                         input logic [31:0] imm);
        @(posedge sys_clk_i);
        exp_dst = {1'b0, exp_dst[2:0] + 3'h1};
        op_valid_i <= 1'b1;
        op_i <= op;
        cond_i <= cond;
        dest_reg_i <= exp_dst;
        lsb_i <= lsb;
        width_i <= w;
        rot_i <= rot;
        it_mask_i <= mask_v;
        imm_offset_i <= imm;
        first_source_reg_i <= v;
        operand_reg_i <= v;
        dest_old_i <= old_v;
        nzcv_i <= flags_v;
        #1 pc_cap = pc;
        @(posedge sys_clk_i);
        op_valid_i <= 1'b0;
        #1;
    endtask

    task automatic chk_wb(input logic [31:0] exp);
        chk({31'h0, wr_en_o}, 32'h1);
        chk({28'h0, wr_reg_o}, {28'h0, exp_dst});
        chk(wr_data_o, exp);
        chk({31'h0, branch_o}, 32'h0);
    endtask

    task automatic chk_br(input logic b, input logic f, input logic [31:0] tgt);
        chk({31'h0, branch_o}, {31'h0, b});
        chk({31'h0, invalid_state_fault_o}, {31'h0, f});
        if (b) begin
            chk(branch_target_o, tgt);
        end
    endtask

    function automatic logic [31:0] fld(input logic [31:0] v, input int lsb, input int w,
                                        input bit sgn);
        logic [31:0] m;
        logic [31:0] r;
        m = (w == 32) ? 32'hFFFF_FFFF : ((32'h1 << w) - 32'h1);
        r = (v >> lsb) & m;
        if (sgn && r[w - 1]) begin
            r = r | ~m;
        end
        return r;
    endfunction

    function automatic logic [31:0] ext(input bfxbr_op_t op, input logic [31:0] v, input int r);
        logic [31:0] x;
        x = (v >> (8 * r)) | (v << (32 - 8 * r));
        case (op)
            BFXBR_OP_SBYTE: ext = {{24{x[7]}}, x[7:0]};
            BFXBR_OP_UBYTE: ext = {24'h0, x[7:0]};
            BFXBR_OP_SHALF: ext = {{16{x[15]}}, x[15:0]};
            default: ext = {16'h0, x[15:0]};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_fields();
        int lsbs [4] = '{20, 0, 31, 9};
        int wids [4] = '{4, 32, 1, 10};
        for (int i = 0; i < 8; i++) begin
            issue(bfxbr_op_t'(i < 4 ? BFXBR_OP_SFX : BFXBR_OP_UFX), 4'hE, 32'hC3A5_96F1,
                  5'(lsbs[i % 4]), 6'(wids[i % 4]), 2'h0, 32'h0);
            chk_wb(fld(32'hC3A5_96F1, lsbs[i % 4], wids[i % 4], i < 4));
        end
        old_v = 32'hFFFF_FFFF;
        issue(BFXBR_OP_FCLR, 4'hE, 32'h0, 5'h08, 6'h0C, 2'h0, 32'h0);
        chk_wb(32'hFFF0_00FF);
        old_v = 32'h1234_5678;
        issue(BFXBR_OP_FINS, 4'hE, 32'hFFFF_FABC, 5'h08, 6'h0C, 2'h0, 32'h0);
        chk_wb(32'h123A_BC78);
    endtask

    task automatic t_extend();
        bfxbr_op_t ops [4] = '{BFXBR_OP_SBYTE, BFXBR_OP_UBYTE, BFXBR_OP_SHALF, BFXBR_OP_UHALF};
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 4; k++) begin
                issue(ops[k], 4'hE, 32'h80F1_7F82, 5'h0, 6'h1, 2'(r), 32'h0);
                chk_wb(ext(ops[k], 32'h80F1_7F82, r));
            end
        end
    endtask

    task automatic t_branch();
        issue(BFXBR_OP_BIMM, 4'hE, 32'h0, 5'h0, 6'h1, 2'h0, BFXBR_FAR_MAX);
        chk_br(1'b1, 1'b0, pc_cap + BFXBR_FAR_MAX);
        chk({31'h0, wr_en_o}, 32'h0);
        flags_v = 4'h4;
        issue(BFXBR_OP_BIMM, 4'h0, 32'h0, 5'h0, 6'h1, 2'h0, BFXBR_NEAR_MIN);
        chk_br(1'b1, 1'b0, pc_cap + BFXBR_NEAR_MIN);
        issue(BFXBR_OP_BIMM, 4'h0, 32'h0, 5'h0, 6'h1, 2'h0, 32'h0010_0000);
        chk_br(1'b1, 1'b0, pc_cap + BFXBR_NEAR_MAX);
        flags_v = 4'h0;
        issue(BFXBR_OP_BIMM, 4'h0, 32'h0, 5'h0, 6'h1, 2'h0, 32'h0000_0100);
        chk_br(1'b0, 1'b0, 32'h0);
        issue(BFXBR_OP_CALL_IMM, 4'hE, 32'h0, 5'h0, 6'h1, 2'h0, BFXBR_FAR_MIN);
        chk_br(1'b1, 1'b0, pc_cap + BFXBR_FAR_MIN);
        chk({31'h0, wr_en_o}, 32'h1);
        chk({28'h0, wr_reg_o}, {28'h0, BFXBR_LINK_REG});
        chk(wr_data_o, pc_cap + 32'h4);
        @(posedge sys_clk_i);
        #1 chk(r14, pc_cap + 32'h4);
        exp_dst = 4'h0;
        issue(BFXBR_OP_JUMP_IND, 4'hE, 32'h2000_0101, 5'h0, 6'h1, 2'h0, 32'h0);
        chk_br(1'b1, 1'b0, 32'h2000_0100);
        issue(BFXBR_OP_CALL_IND, 4'hE, 32'h0000_3001, 5'h0, 6'h1, 2'h0, 32'h0);
        chk_br(1'b1, 1'b0, 32'h0000_3000);
        chk({31'h0, wr_en_o}, 32'h1);
        issue(BFXBR_OP_CALL_IND, 4'hE, 32'h0000_4000, 5'h0, 6'h1, 2'h0, 32'h0);
        chk_br(1'b0, 1'b1, 32'h0);
        issue(BFXBR_OP_JUMP_IND, 4'hE, 32'h0000_4002, 5'h0, 6'h1, 2'h0, 32'h0);
        chk_br(1'b0, 1'b1, 32'h0);
    endtask

    task automatic t_ztest();
        // Flags contradict the operand so a flag-based test would go the wrong way
        for (int i = 0; i < 4; i++) begin
            flags_v = i[0] ? 4'h4 : 4'h0;
            issue(bfxbr_op_t'(i < 2 ? BFXBR_OP_ZTEST : BFXBR_OP_NZTEST), 4'hE,
                  i[0] ? 32'h5 : 32'h0, 5'h0, 6'h1, 2'h0, i[1] ? 32'h4 : 32'h82);
            chk_br((i < 2) ^ i[0], 1'b0, pc_cap + (i[1] ? 32'h4 : 32'h82));
        end
    endtask

    task automatic t_ifthen();
        mask_v = 4'h5;
        flags_v = 4'h4;
        issue(BFXBR_OP_ITPFX, 4'h0, 32'h0, 5'h0, 6'h1, 2'h0, 32'h0);
        chk({31'h0, in_it_block_o}, 32'h1);
        for (int s = 0; s < 3; s++) begin
            issue(BFXBR_OP_UFX, 4'hE, 32'h0000_00F0, 5'h4, 6'h4, 2'h0, 32'h0);
            chk({31'h0, wr_en_o}, s < 2 ? 32'h1 : 32'h0);
            chk({31'h0, slot_pass_o}, s == 1 ? 32'h0 : 32'h1);
        end
        flags_v = 4'h0;
        issue(BFXBR_OP_BIMM, 4'hE, 32'h0, 5'h0, 6'h1, 2'h0, 32'h40);
        chk_br(1'b0, 1'b0, 32'h0);
        chk({31'h0, in_it_block_o}, 32'h0);
        mask_v = 4'h8;
        issue(BFXBR_OP_ITPFX, BFXBR_COND_ALWAYS, 32'h0, 5'h0, 6'h1, 2'h0, 32'h0);
        chk({31'h0, in_it_block_o}, 32'h1);
        issue(BFXBR_OP_CALL_IND, 4'hE, 32'h0000_5001, 5'h0, 6'h1, 2'h0, 32'h0);
        chk_br(1'b1, 1'b0, 32'h0000_5000);
        chk({31'h0, in_it_block_o}, 32'h0);
        chk({31'h0, slot_pass_o}, 32'h1);
        // Four back-to-back ops use up a four-slot block
        mask_v = 4'h1;
        issue(BFXBR_OP_ITPFX, BFXBR_COND_ALWAYS, 32'h0, 5'h0, 6'h1, 2'h0, 32'h0);
        @(posedge sys_clk_i);
        op_i <= BFXBR_OP_NONE;
        op_valid_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1 chk({31'h0, in_it_block_o}, 32'h1);
        @(posedge sys_clk_i);
        op_valid_i <= 1'b0;
        #1 chk({31'h0, in_it_block_o}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n_i = 1'b0;
        op_valid_i = 1'b0;
        op_i = BFXBR_OP_NONE;
        {cond_i, dest_reg_i, it_mask_i, nzcv_i, exp_dst, flags_v, mask_v} = '0;
        {lsb_i, width_i, rot_i} = '0;
        {imm_offset_i, first_source_reg_i, operand_reg_i, dest_old_i, old_v} = '0;
        fail_count = 0;
        compares = 0;
        repeat (4) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        #1;
        chk({29'h0, wr_en_o, branch_o, in_it_block_o}, 32'h0);
        chk({31'h0, slot_pass_o}, 32'h1);
        t_fields();
        t_extend();
        t_branch();
        t_ztest();
        t_ifthen();
        finish_test();
    end
endmodule
